// File: bench/bpm_bus_port_bench.sv
/* Bench of the bus port pin mux: table of host cycles, then hand tests.
   Assumes the host model and checker are compiled before it. */
module bpm_bus_port_bench
  import bpm_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, clkEn, cfgAleActiveHigh, portbDirWe, portbOutWe;
  logic addressLatchStrobe, readStrobeN, writeStrobeN, byteHighEnableN;
  logic chipSelectN, byteHighN, hostReadActive, hostWriteValid;
  bpm_mode_t cfgBusMode;
  logic [7:0] cfgPortbChipSel, cfgPortbOpenDrain, portbDirData;
  logic [7:0] portbOutData, portbIn, portbOut, portbOe, portbInput;
  logic [7:0] portbDir;
  logic [2:0] cfgPortcOutput, cfgPortcAddress, cfgPortcLatched;
  logic [2:0] cfgPortcOpenDrain, portcIn, portcOut, portcOe, portcAddress;
  logic [26:0] termEnable;
  bpm_terms_t termMask, termMatch;
  logic [15:0] hostReadData, sharedBusIn, sharedBusOut, sharedBusOe;
  logic [15:0] decAddress, hostWriteData, q;
  logic [10:0] chipSelect, s;
  logic [66:0] rows [4];
  logic [66:0] r;
  int fail_count = 0;
  int n_tests = 0;

  bpm_bus_port dut (.*);
  bpm_host_model host (.*);

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    n_tests++;
    if (got !== exp)
    begin
      fail_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic logic [10:0] sel_of(input int k);
    if (k < 16)
      return 11'h001 << (k / 4);
    if (k < 24)
      return 11'h010 << ((k - 16) / 2);
    return 11'h100 << (k - 24);
  endfunction

  initial
  begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    final_report();
  end

  initial
  begin
    // Reset rises after time zero so the flops see a real rising edge.
    reset = 1'b0;
    #1 reset = 1'b1;
    clkEn = 1'b1;
    cfgBusMode = BPM_MUX8;
    cfgAleActiveHigh = 1'b1;
    cfgPortbChipSel = 8'h00;
    cfgPortbOpenDrain = 8'h00;
    {portbDirWe, portbOutWe, portbDirData, portbOutData} = 18'h00000;
    {cfgPortcOutput, cfgPortcOpenDrain, portcIn, portbIn} = 17'h00000;
    cfgPortcAddress = 3'h7;
    cfgPortcLatched = 3'h1;
    hostReadData = 16'hc3a6;
    termEnable = 27'h7ffffff;
    for (int k = 0; k < 27; k++)
    begin
      termMask[k] = 20'h0ffff;
      termMatch[k] = 20'h01000 + 20'(k);
    end
    rows[0] = {BPM_MUX8, 1'b1, 16'h12a5, 16'h003c, 16'h123c, 16'h12a6};
    rows[1] = {BPM_MUX16, 1'b0, 16'hf00f, 16'hbeef, 16'hbeef, 16'hc3a6};
    rows[2] = {BPM_NMUX16, 1'b1, 16'h0ff0, 16'h5a00, 16'h5a00, 16'h0ff0};
    rows[3] = {BPM_NMUX8, 1'b1, 16'h8001, 16'h0000, 16'h5a00, 16'h8001};
    repeat (20) @(posedge ref_clk);
    check(chipSelect, 11'h000, "reset selects");
    check(byteHighN, 1'b1, "reset byte high");
    reset <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      r = rows[i];
      cfgBusMode <= bpm_mode_t'(r[66:65]);
      cfgAleActiveHigh <= r[64];
      portbIn <= r[47:40];
      host.write_cycle(r[63:48], r[47:32]);
      check(decAddress, r[63:48], "address");
      check(hostWriteData, r[31:16], "write data");
      check(byteHighN, 1'b0, "byte high latched");
      host.read_cycle(r[63:48], q);
      check(q, r[15:0], "read data");
      check(hostReadActive, 1'b0, "read ended");
      $display("row %0d done", i);
    end
    cfgBusMode <= BPM_MUX8;
    portcIn <= 3'b101;
    host.addr_phase(16'h0000);
    portcIn <= 3'b010;
    repeat (5) @(posedge ref_clk);
    check(portcAddress, 3'b011, "port C address");
    $display("port C input test done");
    cfgBusMode <= BPM_MUX16;
    cfgPortcOutput <= 3'h7;
    cfgPortbChipSel <= 8'hff;
    for (int k = 0; k < 27; k++)
    begin
      s = sel_of(k);
      host.addr_phase(16'h1000 + 16'(k));
      repeat (4) @(posedge ref_clk);
      check(chipSelect, s, "decoder select");
      check({portcOut, portbOut}, 11'(~s), "select pins");
      check({portcOe, portbOe}, 11'h7ff, "select enables");
    end
    $display("decoder test done");
    host.release_chip();
    check(chipSelect, 11'h000, "standby");
    check({portcOut, portbOut}, 11'h7ff, "standby pins");
    host.addr_phase(16'h1000);
    reset <= 1'b1;
    @(posedge ref_clk);
    check(chipSelect, 11'h000, "mid reset");
    reset <= 1'b0;
    $display("standby and reset test done");
    cfgPortbChipSel <= 8'h00;
    {portbDirWe, portbOutWe} <= 2'b11;
    portbDirData <= 8'ha5;
    portbOutData <= 8'h0f;
    portbIn <= 8'h3c;
    @(posedge ref_clk);
    {portbDirWe, portbOutWe} <= 2'b00;
    repeat (5) @(posedge ref_clk);
    check(portbDir, 8'ha5, "direction");
    check(portbOe, 8'ha5, "port B enables");
    check(portbOut, 8'h0f, "port B value");
    check(portbInput, 8'h3c, "port B input");
    cfgPortbOpenDrain <= 8'hff;
    repeat (3) @(posedge ref_clk);
    check(portbOe, 8'ha0, "open drain");
    $display("port B test done");
    final_report();
  end
endmodule

// File: bench/bpm_bus_port_chk.sv
/* Assertions on the ports of the bus port pin mux.
   Assumes the bind below attaches it to every instance. */
`include "bpm_cfg.svh"

module bpm_bus_port_chk
  import bpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire bpm_mode_t cfgBusMode,
  input wire logic [`BPM_PORTB_W-1:0] cfgPortbOpenDrain,
  input wire logic [`BPM_PORTB_W-1:0] portbOut,
  input wire logic [`BPM_PORTB_W-1:0] portbOe,
  input wire logic portbDirWe,
  input wire logic [`BPM_PORTB_W-1:0] portbDirData,
  input wire logic [`BPM_PORTB_W-1:0] portbDir,
  input wire logic [`BPM_BUS_W-1:0] hostReadData,
  input wire logic [`BPM_BUS_W-1:0] sharedBusOut,
  input wire logic [`BPM_BUS_W-1:0] sharedBusOe,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic chipSelectN,
  input wire logic hostWriteValid,
  input wire logic [`BPM_NUM_CS-1:0] chipSelect
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence readHeld;
    !readStrobeN && !chipSelectN && cfgBusMode == BPM_MUX16;
  endsequence
  sequence writeEnded;
    $past(writeStrobeN, 3) && !$past(writeStrobeN, 4);
  endsequence
  chk_read_drive: assert property (readHeld [*4] |-> sharedBusOe == 16'hffff)
    else $error("read not driven on bus");
  chk_read_value: assert property (sharedBusOe[0]
    |-> sharedBusOut[7:0] == $past(hostReadData[7:0]))
    else $error("read data wrong on bus");
  chk_oe_cause: assert property (|sharedBusOe
    |-> !$past(readStrobeN, 3) && !$past(chipSelectN, 3))
    else $error("bus driven outside read");
  chk_nmux_quiet: assert property (cfgBusMode[1] && $past(cfgBusMode[1])
    |-> sharedBusOe == 16'h0000)
    else $error("non-muxed bus driven");
  chk_mux8_high: assert property (cfgBusMode == BPM_MUX8
    && $past(cfgBusMode) == BPM_MUX8 |-> sharedBusOe[15:8] == 8'h00)
    else $error("high byte driven in 8-bit mode");
  chk_cs_standby: assert property (chipSelectN [*5] |-> chipSelect == 11'h000)
    else $error("select active in standby");
  chk_reset_clear: assert property (disable iff (1'b0)
    reset |-> chipSelect == 11'h000 && sharedBusOe == 16'h0000)
    else $error("reset left outputs active");
  chk_write_pulse: assert property (hostWriteValid
    |-> writeEnded ##1 !hostWriteValid)
    else $error("write valid at wrong time");
  chk_dir_write: assert property (portbDirWe
    |=> portbDir == $past(portbDirData))
    else $error("direction write lost");
  chk_od_release: assert property ($stable(cfgPortbOpenDrain)
    && $stable(cfgBusMode) && cfgBusMode != BPM_NMUX16
    |-> (portbOe & portbOut & cfgPortbOpenDrain) == 8'h00)
    else $error("open-drain pin drives one");
endmodule

bind bpm_bus_port bpm_bus_port_chk chk (.*);

// File: bench/bpm_host_model.sv
/* Host bus model driving strobes and the shared bus pins on ref_clk.
   Assumes the bench calls one of its tasks at a time. */
module bpm_host_model
  import bpm_pkg::*;
(
  input wire logic ref_clk,
  input wire bpm_mode_t cfgBusMode,
  input wire logic cfgAleActiveHigh,
  input wire logic [15:0] sharedBusOut,
  input wire logic [15:0] sharedBusOe,
  output logic [15:0] sharedBusIn,
  output logic addressLatchStrobe,
  output logic readStrobeN,
  output logic writeStrobeN,
  output logic byteHighEnableN,
  output logic chipSelectN
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] hostVal = 16'h0000;
  logic [15:0] hostEn = 16'hffff;
  // Bits nobody drives show the inverse of the last host value.
  assign sharedBusIn = (sharedBusOe & sharedBusOut)
    | (~sharedBusOe & ~(hostVal ^ hostEn));
  initial
  begin
    addressLatchStrobe = 1'b0;
    readStrobeN = 1'b1;
    writeStrobeN = 1'b1;
    byteHighEnableN = 1'b1;
    chipSelectN = 1'b1;
  end
  task automatic addr_phase(input logic [15:0] a);
    @(posedge ref_clk);
    hostVal <= a;
    hostEn <= 16'hffff;
    chipSelectN <= 1'b0;
    byteHighEnableN <= 1'b0;
    addressLatchStrobe <= cfgAleActiveHigh;
    repeat (4) @(posedge ref_clk);
    // Address stays valid across the trailing edge.
    addressLatchStrobe <= ~cfgAleActiveHigh;
    repeat (4) @(posedge ref_clk);
  endtask
  task automatic write_cycle(input logic [15:0] a, input logic [15:0] d);
    addr_phase(a);
    if (cfgBusMode == BPM_MUX16)
      hostVal <= d;
    else if (cfgBusMode == BPM_MUX8)
      hostVal <= {a[15:8], d[7:0]};
    writeStrobeN <= 1'b0;
    repeat (5) @(posedge ref_clk);
    writeStrobeN <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic read_cycle(input logic [15:0] a, output logic [15:0] q);
    addr_phase(a);
    hostEn <= cfgBusMode == BPM_MUX16 ? 16'h0000 :
      cfgBusMode == BPM_MUX8 ? 16'hff00 : 16'hffff;
    readStrobeN <= 1'b0;
    repeat (6) @(posedge ref_clk);
    q = sharedBusIn;
    readStrobeN <= 1'b1;
    repeat (5) @(posedge ref_clk);
  endtask
  task automatic release_chip();
    @(posedge ref_clk);
    chipSelectN <= 1'b1;
    repeat (6) @(posedge ref_clk);
  endtask
endmodule

// File: src/bpm_bus_port.sv
/*
  Pin functions of the host bus port: shared address/data pins, port B
  and port C roles, address latching and the product-term decoder.
  Assumes a host microcontroller bus on the pins and same-clock memory
  logic on the user side; all pins are sampled through two flip-flops.

  // Contract
  // - Port B I/O direction from direction bit.
  // - Four terms low pins, two terms high.
  // - Non-muxed 16-bit: port B is high data.
  // - Port C inputs feed decoder, address or logic.
  // - Port C address input may be strobe-latched.
  // - Port C output driven by one term.
  // - Muxed: low pins share address and data.
  // - Muxed address captured by latch strobe.
  // - Data phase direction follows read/write strobes.
  // - Muxed 16-bit: high pins share address/data.
  // - Non-muxed: low pins are address only.
  // - Non-muxed or 8-bit: high pins address only.
  // - Capture on trailing strobe edge, polarity configurable.
  // - Chip select high puts decoder in standby.
  // - Reset deselects all decoder outputs.
  // - Each port C pin: address input or select.
*/
`include "bpm_cfg.svh"

module bpm_bus_port
  import bpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire bpm_mode_t cfgBusMode,
  input wire logic cfgAleActiveHigh,
  input wire logic [`BPM_PORTB_W-1:0] cfgPortbChipSel,
  input wire logic [`BPM_PORTB_W-1:0] cfgPortbOpenDrain,
  input wire logic [`BPM_PORTC_W-1:0] cfgPortcOutput,
  input wire logic [`BPM_PORTC_W-1:0] cfgPortcAddress,
  input wire logic [`BPM_PORTC_W-1:0] cfgPortcLatched,
  input wire logic [`BPM_PORTC_W-1:0] cfgPortcOpenDrain,
  input wire logic [`BPM_NUM_TERMS-1:0] termEnable,
  input wire bpm_terms_t termMask,
  input wire bpm_terms_t termMatch,
  input wire logic portbDirWe,
  input wire logic [`BPM_PORTB_W-1:0] portbDirData,
  input wire logic portbOutWe,
  input wire logic [`BPM_PORTB_W-1:0] portbOutData,
  input wire logic [`BPM_BUS_W-1:0] hostReadData,
  input wire logic [`BPM_BUS_W-1:0] sharedBusIn,
  output logic [`BPM_BUS_W-1:0] sharedBusOut,
  output logic [`BPM_BUS_W-1:0] sharedBusOe,
  input wire logic addressLatchStrobe,
  input wire logic readStrobeN,
  input wire logic writeStrobeN,
  input wire logic byteHighEnableN,
  input wire logic chipSelectN,
  input wire logic [`BPM_PORTB_W-1:0] portbIn,
  output logic [`BPM_PORTB_W-1:0] portbOut,
  output logic [`BPM_PORTB_W-1:0] portbOe,
  input wire logic [`BPM_PORTC_W-1:0] portcIn,
  output logic [`BPM_PORTC_W-1:0] portcOut,
  output logic [`BPM_PORTC_W-1:0] portcOe,
  output logic [`BPM_BUS_W-1:0] decAddress,
  output logic [`BPM_PORTC_W-1:0] portcAddress,
  output logic byteHighN,
  output logic hostReadActive,
  output logic [`BPM_BUS_W-1:0] hostWriteData,
  output logic hostWriteValid,
  output logic [`BPM_PORTB_W-1:0] portbInput,
  output logic [`BPM_PORTB_W-1:0] portbDir,
  output logic [`BPM_NUM_CS-1:0] chipSelect
);

  logic [`BPM_SYNC_W-1:0] pinRaw;
  logic [`BPM_SYNC_W-1:0] syncStage1_ff;
  logic [`BPM_SYNC_W-1:0] syncStage2_ff;
  logic [`BPM_BUS_W-1:0] busS;
  logic [`BPM_PORTB_W-1:0] portbS;
  logic [`BPM_PORTC_W-1:0] portcS;
  logic aleActive;
  logic aleTrailing;
  logic muxed;
  logic readActive;
  logic writeActive;
  logic writeTrailing;
  logic [`BPM_BUS_W-1:0] addrEff;
  logic [`BPM_PORTC_W-1:0] portcEff;
  logic bheEff;
  bpm_decin_t decIn;

  logic aleActivePrev_ff, nxt_aleActivePrev;
  logic [`BPM_BUS_W-1:0] addrLatch_ff, nxt_addrLatch;
  logic [`BPM_PORTC_W-1:0] portcLatch_ff, nxt_portcLatch;
  logic bheLatch_ff, nxt_bheLatch;
  logic [`BPM_BUS_W-1:0] decAddress_ff, nxt_decAddress;
  logic [`BPM_PORTC_W-1:0] portcAddress_ff, nxt_portcAddress;
  logic byteHighN_ff, nxt_byteHighN;

  logic writePrev_ff, nxt_writePrev;
  logic [`BPM_BUS_W-1:0] writeData_ff, nxt_writeData;
  logic writeValid_ff, nxt_writeValid;
  logic [`BPM_PORTB_W-1:0] portbDir_ff, nxt_portbDir;
  logic [`BPM_PORTB_W-1:0] portbReg_ff, nxt_portbReg;
  logic [`BPM_PORTB_W-1:0] portbInput_ff, nxt_portbInput;

  logic [`BPM_BUS_W-1:0] busOut_ff, nxt_busOut;
  logic [`BPM_BUS_W-1:0] busOe_ff, nxt_busOe;
  logic [`BPM_PORTB_W-1:0] portbOut_ff, nxt_portbOut;
  logic [`BPM_PORTB_W-1:0] portbOe_ff, nxt_portbOe;
  logic [`BPM_PORTC_W-1:0] portcOut_ff, nxt_portcOut;
  logic [`BPM_PORTC_W-1:0] portcOe_ff, nxt_portcOe;

  // Open-drain pins only pull low and release for a one.
  function automatic logic pinEnable(input logic drive, input logic od,
                                     input logic val);
    pinEnable = drive & (~od | ~val);
  endfunction

  // Pin synchroniser; the first stage is read only by the second.
  assign pinRaw = {chipSelectN, byteHighEnableN, writeStrobeN, readStrobeN,
                   addressLatchStrobe, portcIn, portbIn, sharedBusIn};

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      syncStage1_ff <= `BPM_SYNC_RESET;
      syncStage2_ff <= `BPM_SYNC_RESET;
    end
    else if (clkEn)
    begin
      syncStage1_ff <= pinRaw;
      syncStage2_ff <= syncStage1_ff;
    end
  end

  assign busS = syncStage2_ff[`BPM_SYNC_BUS_LSB +: `BPM_BUS_W];
  assign portbS = syncStage2_ff[`BPM_SYNC_PORTB_LSB +: `BPM_PORTB_W];
  assign portcS = syncStage2_ff[`BPM_SYNC_PORTC_LSB +: `BPM_PORTC_W];
  assign aleActive = ~(syncStage2_ff[`BPM_SYNC_ALE] ^ cfgAleActiveHigh);
  assign aleTrailing = aleActivePrev_ff & ~aleActive;
  assign muxed = (cfgBusMode == BPM_MUX8) || (cfgBusMode == BPM_MUX16);
  assign readActive = ~syncStage2_ff[`BPM_SYNC_RDN]
                    & ~syncStage2_ff[`BPM_SYNC_CSN];
  assign writeActive = ~syncStage2_ff[`BPM_SYNC_WRN]
                     & ~syncStage2_ff[`BPM_SYNC_CSN];
  assign writeTrailing = writePrev_ff & ~writeActive;

  // Address path: latched on the strobe's trailing edge or transparent.
  always_comb
  begin
    nxt_aleActivePrev = aleActive;
    nxt_addrLatch = aleTrailing ? busS : addrLatch_ff;
    nxt_portcLatch = aleTrailing ? portcS : portcLatch_ff;
    nxt_bheLatch = aleTrailing ? syncStage2_ff[`BPM_SYNC_BHEN]
                               : bheLatch_ff;
    addrEff[7:0] = muxed ? addrLatch_ff[7:0] : busS[7:0];
    addrEff[15:8] = (cfgBusMode == BPM_MUX16) ? addrLatch_ff[15:8]
                                              : busS[15:8];
    bheEff = muxed ? bheLatch_ff : syncStage2_ff[`BPM_SYNC_BHEN];
    for (int i = 0; i < `BPM_PORTC_W; i++)
    begin
      if (cfgPortcOutput[i])
        portcEff[i] = 1'b0;
      else if (cfgPortcAddress[i] && cfgPortcLatched[i])
        portcEff[i] = portcLatch_ff[i];
      else
        portcEff[i] = portcS[i];
    end
    nxt_decAddress = addrEff;
    nxt_portcAddress = portcEff & cfgPortcAddress;
    nxt_byteHighN = bheEff;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      aleActivePrev_ff <= 1'b0;
      addrLatch_ff <= `BPM_ADDR_RESET;
      portcLatch_ff <= `BPM_PORTC_RESET;
      bheLatch_ff <= 1'b1;
      decAddress_ff <= `BPM_ADDR_RESET;
      portcAddress_ff <= `BPM_PORTC_RESET;
      byteHighN_ff <= 1'b1;
    end
    else if (clkEn)
    begin
      aleActivePrev_ff <= nxt_aleActivePrev;
      addrLatch_ff <= nxt_addrLatch;
      portcLatch_ff <= nxt_portcLatch;
      bheLatch_ff <= nxt_bheLatch;
      decAddress_ff <= nxt_decAddress;
      portcAddress_ff <= nxt_portcAddress;
      byteHighN_ff <= nxt_byteHighN;
    end
  end

  assign decIn = {bheEff, portcEff, addrEff};

  bpm_decoder uDecoder (
    .ref_clk(ref_clk),
    .reset(reset),
    .clkEn(clkEn),
    .standby(syncStage2_ff[`BPM_SYNC_CSN]),
    .decIn(decIn),
    .termEnable(termEnable),
    .termMask(termMask),
    .termMatch(termMatch),
    .chipSel(chipSelect)
  );

  // Write capture and port B I/O registers.
  always_comb
  begin
    nxt_writePrev = writeActive;
    nxt_writeData = writeData_ff;
    if (writeActive)
    begin
      if (cfgBusMode == BPM_NMUX16)
        nxt_writeData = {portbS, `BPM_BYTE_RESET};
      else if (muxed)
        nxt_writeData = busS;
    end
    nxt_writeValid = writeTrailing;
    nxt_portbDir = portbDirWe ? portbDirData : portbDir_ff;
    nxt_portbReg = portbOutWe ? portbOutData : portbReg_ff;
    nxt_portbInput = portbS;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      writePrev_ff <= 1'b0;
      writeData_ff <= `BPM_DATA_RESET;
      writeValid_ff <= 1'b0;
      portbDir_ff <= `BPM_BYTE_RESET;
      portbReg_ff <= `BPM_BYTE_RESET;
      portbInput_ff <= `BPM_BYTE_RESET;
    end
    else if (clkEn)
    begin
      writePrev_ff <= nxt_writePrev;
      writeData_ff <= nxt_writeData;
      writeValid_ff <= nxt_writeValid;
      portbDir_ff <= nxt_portbDir;
      portbReg_ff <= nxt_portbReg;
      portbInput_ff <= nxt_portbInput;
    end
  end

  // Pin drivers.
  always_comb
  begin
    logic val;
    logic drive;
    val = 1'b0;
    drive = 1'b0;
    nxt_busOut = hostReadData;
    nxt_busOe[7:0] = {8{muxed & readActive}};
    nxt_busOe[15:8] = {8{(cfgBusMode == BPM_MUX16) & readActive}};
    for (int p = 0; p < `BPM_PORTB_W; p++)
    begin
      if (cfgBusMode == BPM_NMUX16)
      begin
        val = hostReadData[`BPM_BYTE_W + p];
        drive = readActive;
      end
      else if (cfgPortbChipSel[p])
      begin
        val = ~chipSelect[p];
        drive = 1'b1;
      end
      else
      begin
        val = portbReg_ff[p];
        drive = portbDir_ff[p];
      end
      nxt_portbOut[p] = val;
      nxt_portbOe[p] = (cfgBusMode == BPM_NMUX16) ? drive
                       : pinEnable(drive, cfgPortbOpenDrain[p], val);
    end
    for (int c = 0; c < `BPM_PORTC_W; c++)
    begin
      nxt_portcOut[c] = ~chipSelect[`BPM_CS_PORTC_BASE + c];
      nxt_portcOe[c] = pinEnable(cfgPortcOutput[c], cfgPortcOpenDrain[c],
                                 nxt_portcOut[c]);
    end
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
    begin
      busOut_ff <= `BPM_DATA_RESET;
      busOe_ff <= `BPM_DATA_RESET;
      portbOut_ff <= `BPM_BYTE_RESET;
      portbOe_ff <= `BPM_BYTE_RESET;
      portcOut_ff <= `BPM_PORTC_RESET;
      portcOe_ff <= `BPM_PORTC_RESET;
    end
    else if (clkEn)
    begin
      busOut_ff <= nxt_busOut;
      busOe_ff <= nxt_busOe;
      portbOut_ff <= nxt_portbOut;
      portbOe_ff <= nxt_portbOe;
      portcOut_ff <= nxt_portcOut;
      portcOe_ff <= nxt_portcOe;
    end
  end

  assign sharedBusOut = busOut_ff;
  assign sharedBusOe = busOe_ff;
  assign portbOut = portbOut_ff;
  assign portbOe = portbOe_ff;
  assign portcOut = portcOut_ff;
  assign portcOe = portcOe_ff;
  assign decAddress = decAddress_ff;
  assign portcAddress = portcAddress_ff;
  assign byteHighN = byteHighN_ff;
  assign hostReadActive = readActive;
  assign hostWriteData = writeData_ff;
  assign hostWriteValid = writeValid_ff;
  assign portbInput = portbInput_ff;
  assign portbDir = portbDir_ff;

endmodule

// File: src/bpm_cfg.svh
/*
  Constants of the bus port pin mux: widths, field positions inside the
  synchroniser word, product-term layout and reset values.
  Assumes it is included by the package and by every design module.
*/
`ifndef BPM_CFG_SVH
`define BPM_CFG_SVH

`define BPM_BUS_W 16
`define BPM_BYTE_W 8
`define BPM_PORTB_W 8
`define BPM_PORTC_W 3
`define BPM_NUM_CS 11
`define BPM_NUM_TERMS 27
`define BPM_DEC_IN_W 20
`define BPM_LOW_PINS 4
`define BPM_HIGH_PINS 8
`define BPM_LOW_TERMS 4
`define BPM_HIGH_TERMS 2
`define BPM_HIGH_TERM_BASE 16
`define BPM_PORTC_TERM_BASE 24
`define BPM_CS_PORTC_BASE 8

`define BPM_SYNC_W 32
`define BPM_SYNC_BUS_LSB 0
`define BPM_SYNC_PORTB_LSB 16
`define BPM_SYNC_PORTC_LSB 24
`define BPM_SYNC_ALE 27
`define BPM_SYNC_RDN 28
`define BPM_SYNC_WRN 29
`define BPM_SYNC_BHEN 30
`define BPM_SYNC_CSN 31
`define BPM_SYNC_RESET 32'hf000_0000

`define BPM_ADDR_RESET 16'h0000
`define BPM_DATA_RESET 16'h0000
`define BPM_BYTE_RESET 8'h00
`define BPM_PORTC_RESET 3'h0
`define BPM_CS_RESET 11'h000

`endif

// File: src/bpm_decoder.sv
/*
  Product-term address decoder feeding the port B and port C select pins.
  Assumes its decoder inputs are already synchronised to ref_clk.
*/
`include "bpm_cfg.svh"

module bpm_decoder
  import bpm_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic standby,
  input wire bpm_decin_t decIn,
  input wire logic [`BPM_NUM_TERMS-1:0] termEnable,
  input wire bpm_terms_t termMask,
  input wire bpm_terms_t termMatch,
  output logic [`BPM_NUM_CS-1:0] chipSel
);

  logic [`BPM_NUM_TERMS-1:0] termHit;
  logic [`BPM_NUM_CS-1:0] csSum;
  logic [`BPM_NUM_CS-1:0] chipSel_ff;
  logic [`BPM_NUM_CS-1:0] nxt_chipSel;

  // An enabled term is true when every unmasked input equals its match bit.
  function automatic logic termMatches(input bpm_decin_t in,
                                       input bpm_decin_t mask,
                                       input bpm_decin_t match,
                                       input logic en);
    termMatches = en & (((in ^ match) & mask) == '0);
  endfunction

  genvar t;
  genvar p;
  generate
    for (t = 0; t < `BPM_NUM_TERMS; t++)
    begin : gTerm
      assign termHit[t] = termMatches(decIn, termMask[t], termMatch[t],
                                      termEnable[t]);
    end
    for (p = 0; p < `BPM_NUM_CS; p++)
    begin : gSum
      localparam int BASE = (p < `BPM_LOW_PINS) ? p * `BPM_LOW_TERMS :
        (p < `BPM_HIGH_PINS) ?
        `BPM_HIGH_TERM_BASE + (p - `BPM_LOW_PINS) * `BPM_HIGH_TERMS :
        `BPM_PORTC_TERM_BASE + (p - `BPM_CS_PORTC_BASE);
      localparam int CNT = (p < `BPM_LOW_PINS) ? `BPM_LOW_TERMS :
        (p < `BPM_HIGH_PINS) ? `BPM_HIGH_TERMS : 1;
      assign csSum[p] = |termHit[BASE +: CNT];
    end
  endgenerate

  always_comb
  begin
    nxt_chipSel = standby ? `BPM_CS_RESET : csSum;
  end

  always_ff @(posedge ref_clk or posedge reset)
  begin
    if (reset)
      chipSel_ff <= `BPM_CS_RESET;
    else if (clkEn)
      chipSel_ff <= nxt_chipSel;
  end

  assign chipSel = chipSel_ff;

endmodule

// File: src/bpm_pkg.sv
/*
  Types shared by the bus port pin mux modules.
  Assumes bpm_cfg.svh is on the include path.
*/
`include "bpm_cfg.svh"

package bpm_pkg;

  // Host bus organisation selected by configuration.
  typedef enum logic [1:0] {BPM_MUX8, BPM_MUX16, BPM_NMUX8, BPM_NMUX16}
    bpm_mode_t;

  typedef logic [`BPM_DEC_IN_W-1:0] bpm_decin_t;

  typedef logic [`BPM_NUM_TERMS-1:0][`BPM_DEC_IN_W-1:0] bpm_terms_t;

endpackage
